// file: hdl/salr_regs.sv
// Aux output, ADC clock, divider and lock status register bank on Avalon-MM
`timescale 1ns/1ps
`include "salr_map.svh"
// Notes on behaviour
// R1 - Aux source: 0 divided, 1 oscillator
// R2 - Two-bit aux power level, resets to three
// R3 - Aux output on only while bit set
// R4 - ADC enable overrides the clock disable bit
// R5 - Prescale sets lock count cycles to 32 times 1, 2, 4 or 8, not 5, 10, 20 or 40
// R6 - Lock status bit 0, upper bits zero
// R7 - Reserved bits ignore writes, read reset value
module salr_regs
    import salr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic adc_enable_i,
    input wire logic [1:0] lock_count_select_i,
    input wire logic lock_detect_i,
    output logic aux_source_select_o,
    output logic [1:0] aux_power_level_o,
    output logic aux_output_on_o,
    output logic adc_clock_off_o,
    output logic feedback_divider_powerdown_o,
    output logic [10:0] lock_count_cycles_o,
    output logic irq_o
);

    // ============================================================
    // Decode helpers
    // Word index from byte address; low two bits ignored
    function automatic logic [7:0] word_index(input logic [9:0] a);
        word_index = a[9:2];
    endfunction

    // Masked byte-lane write of a register
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] wmask, input logic lane);
        merge = lane ? ((old & ~wmask) | (wd & wmask)) : old;
    endfunction

    salr_state_t s;
    salr_state_t next_s;
    logic take;
    logic [7:0] idx;
    logic [7:0] rd_byte;
    logic [10:0] base;
    logic lock_rise;
    logic lock_fall;
    logic [7:0] mask_byte;

    // ============================================================
    // Next-state logic
    // One wait cycle per access keeps readdata registered and the answer fixed
    always_comb
    begin
        next_s = s;
        take = (avs_read_i || avs_write_i) && !s.ack;
        idx = word_index(avs_address_i);
        rd_byte = 8'h00;
        // Mask register is two bits wide; merge works on a whole byte
        mask_byte = merge({6'h00, s.irq_mask}, avs_writedata_i[7:0], `SALR_WMASK_IRQ,
            avs_byteenable_i[0]);
        next_s.ack = take;
        next_s.lock_q = lock_detect_i;
        lock_rise = lock_detect_i && !s.lock_q;
        lock_fall = !lock_detect_i && s.lock_q;
        // Register writes; reserved positions keep their reset zeros
        if (take && avs_write_i)
        begin
            case (idx)
                `SALR_IDX_QUAD: next_s.quad = merge(s.quad, avs_writedata_i[7:0],
                    `SALR_WMASK_QUAD, avs_byteenable_i[0]); // R7
                `SALR_IDX_AUX: next_s.aux = merge(s.aux, avs_writedata_i[7:0],
                    `SALR_WMASK_AUX, avs_byteenable_i[0]); // R7
                `SALR_IDX_ADCLK: next_s.adclk = merge(s.adclk, avs_writedata_i[7:0],
                    `SALR_WMASK_ADCLK, avs_byteenable_i[0]); // R7
                `SALR_IDX_IRQ_MASK: next_s.irq_mask = mask_byte[1:0];
                default: ;
            endcase
        end
        // Readback; unmapped words read zero
        case (idx)
            `SALR_IDX_QUAD: rd_byte = s.quad;
            `SALR_IDX_AUX: rd_byte = s.aux;
            `SALR_IDX_ADCLK: rd_byte = s.adclk;
            `SALR_IDX_LOCK: rd_byte = {7'h00, s.lock_q}; // R6
            `SALR_IDX_IRQ_STATUS: rd_byte = {6'h00, s.irq_status};
            `SALR_IDX_IRQ_MASK: rd_byte = {6'h00, s.irq_mask};
            default: rd_byte = 8'h00;
        endcase
        if (take && avs_read_i)
        begin
            next_s.rdata = {24'h000000, rd_byte};
        end
        // Status read clears; a new event in the same cycle wins
        if (take && avs_read_i && idx == `SALR_IDX_IRQ_STATUS)
        begin
            next_s.irq_status = 2'h0;
        end
        if (lock_rise)
        begin
            next_s.irq_status[`SALR_IRQ_LOCK_BIT] = 1'b1;
        end
        if (lock_fall)
        begin
            next_s.irq_status[`SALR_IRQ_UNLOCK_BIT] = 1'b1;
        end
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
        // Analog-facing controls
        next_s.aux_out.source_osc = next_s.aux[`SALR_AUX_SRC_BIT]; // R1
        next_s.aux_out.power_level =
            next_s.aux[`SALR_AUX_PWR_HI:`SALR_AUX_PWR_LO]; // R2
        next_s.aux_out.output_on = next_s.aux[`SALR_AUX_ON_BIT]; // R3
        // Enabled ADC always gets its clock, whatever the disable bit holds
        next_s.adc_clk_off = next_s.adclk[`SALR_ADC_CLKDIS_BIT] && !adc_enable_i; // R4
        next_s.ndiv_pd = next_s.adclk[`SALR_NDIV_PD_BIT];
        // Base counts 5,10,20,40; prescale gives 32,64,128,256 (x32 of 1,2,4,8)
        base = `SALR_LD_BASE_0 << lock_count_select_i;
        if (next_s.adclk[`SALR_LD_PRESCALE_BIT])
        begin
            next_s.ld_cycles = `SALR_LD_PRESCALE << lock_count_select_i; // R5
        end
        else
        begin
            next_s.ld_cycles = base;
        end
        if (!rst_n_i)
        begin
            next_s = '0;
            next_s.quad = `SALR_RST_QUAD;
            next_s.aux = `SALR_RST_AUX; // R2
            next_s.adclk = `SALR_RST_ADCLK;
            next_s.aux_out.power_level = 2'(`SALR_RST_AUX >> `SALR_AUX_PWR_LO);
            next_s.ld_cycles = `SALR_LD_BASE_0;
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clock_i)
    begin
        s <= next_s;
    end

    // ============================================================
    // Outputs straight from state
    assign avs_readdata_o = s.rdata;
    assign avs_waitrequest_o = !s.ack;
    assign aux_source_select_o = s.aux_out.source_osc;
    assign aux_power_level_o = s.aux_out.power_level;
    assign aux_output_on_o = s.aux_out.output_on;
    assign adc_clock_off_o = s.adc_clk_off;
    assign feedback_divider_powerdown_o = s.ndiv_pd;
    assign lock_count_cycles_o = s.ld_cycles;
    assign irq_o = s.irq;

endmodule

// file: hdl/salr_map.svh
// Register offsets, field positions, reset values and masks of the aux/lock register bank
`ifndef SALR_MAP_SVH
`define SALR_MAP_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define SALR_IDX_QUAD 8'h71
`define SALR_IDX_AUX 8'h72
`define SALR_IDX_ADCLK 8'h73
`define SALR_IDX_LOCK 8'h7c
`define SALR_IDX_IRQ_STATUS 8'h7d
`define SALR_IDX_IRQ_MASK 8'h7e

// ============================================================
// Reset values
`define SALR_RST_QUAD 8'h60
`define SALR_RST_AUX 8'h32
`define SALR_RST_ADCLK 8'h00
`define SALR_RST_LOCK 8'h00

// ============================================================
// Writable bit masks; all other bits are reserved and read zero
`define SALR_WMASK_QUAD 8'he3
`define SALR_WMASK_AUX 8'h7a
`define SALR_WMASK_ADCLK 8'h07
`define SALR_WMASK_IRQ 8'h03

// ============================================================
// Field positions
`define SALR_AUX_SRC_BIT 6
`define SALR_AUX_PWR_HI 5
`define SALR_AUX_PWR_LO 4
`define SALR_AUX_ON_BIT 3
`define SALR_ADC_CLKDIS_BIT 2
`define SALR_NDIV_PD_BIT 1
`define SALR_LD_PRESCALE_BIT 0
`define SALR_IRQ_LOCK_BIT 0
`define SALR_IRQ_UNLOCK_BIT 1

// ============================================================
// Lock counter cycle selections
`define SALR_LD_BASE_0 11'h005
`define SALR_LD_PRESCALE 11'h020

`endif

// file: hdl/salr_pkg.sv
// Types shared by the aux/lock register bank
package salr_pkg;

    // Aux output controls as seen by the analog side
    typedef struct packed {
        logic source_osc;
        logic [1:0] power_level;
        logic output_on;
    } salr_aux_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] quad;
        logic [7:0] aux;
        logic [7:0] adclk;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic lock_q;
        logic ack;
        logic [31:0] rdata;
        salr_aux_t aux_out;
        logic adc_clk_off;
        logic ndiv_pd;
        logic [10:0] ld_cycles;
        logic irq;
    } salr_state_t;

endpackage

// file: test/salr_regs_props.sv
// Port-level assertions for the aux/lock register bank
`timescale 1ns/1ps
module salr_regs_props
    import salr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic adc_enable_i,
    input wire logic [1:0] lock_count_select_i,
    input wire logic aux_source_select_o,
    input wire logic [1:0] aux_power_level_o,
    input wire logic aux_output_on_o,
    input wire logic adc_clock_off_o,
    input wire logic feedback_divider_powerdown_o,
    input wire logic [10:0] lock_count_cycles_o
);
    // ============================================================
    // Properties
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    adc_override_a: assert property (adc_enable_i |=> !adc_clock_off_o)
        else $error("adc clock off despite enable");
    count_set_a: assert property (lock_count_cycles_o inside
        {11'h005, 11'h00a, 11'h014, 11'h028, 11'h020, 11'h040, 11'h080, 11'h100})
        else $error("lock count outside set");
    count_scale_a: assert property ($onehot(lock_count_cycles_o) |->
        lock_count_cycles_o == (11'h020 << $past(lock_count_select_i)))
        else $error("prescaled count wrong");
    rdata_upper_a: assert property (avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered");
    aux_write_a: assert property (!$stable({aux_source_select_o, aux_power_level_o,
        aux_output_on_o}) |-> $past(avs_write_i) && $past(avs_address_i) == 10'h1c8)
        else $error("aux output changed without write");
    ndiv_write_a: assert property (!$stable(feedback_divider_powerdown_o) |->
        $past(avs_write_i) && $past(avs_address_i) == 10'h1cc)
        else $error("divider powerdown changed without write");
endmodule
bind salr_regs salr_regs_props u_props(.clock_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .adc_enable_i, .lock_count_select_i,
    .aux_source_select_o, .aux_power_level_o, .aux_output_on_o, .adc_clock_off_o,
    .feedback_divider_powerdown_o, .lock_count_cycles_o);

// file: test/salr_regs_tb.sv
// Self-checking bench for the aux/lock register bank
`timescale 1ns/1ps
module salr_regs_tb;
    logic clock_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic adc_enable_i = 0, lock_detect_i = 0, aux_source_select_o, aux_output_on_o;
    logic avs_waitrequest_o, adc_clock_off_o, feedback_divider_powerdown_o, irq_o;
    logic [9:0] avs_address_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [1:0] lock_count_select_i = 0, aux_power_level_o;
    logic [10:0] lock_count_cycles_o;
    logic [7:0] q;
    int mismatches = 0, num_checks = 0;
    salr_regs DUT(.clock_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .adc_enable_i, .lock_count_select_i, .lock_detect_i, .aux_source_select_o,
        .aux_power_level_o, .aux_output_on_o, .adc_clock_off_o, .feedback_divider_powerdown_o,
        .lock_count_cycles_o, .irq_o);
    // ============================================================
    // Helpers
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    // One bus access; request held until waitrequest is seen low
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i <= 0;
        avs_read_i <= 0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        acc(0, a, 8'h00);
        chk("readback", {24'h0, e}, {24'h0, q});
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ============================================================
    // Scenarios
    task t_reset();
        rd(10'h1c4, 8'h60);
        rd(10'h1c8, 8'h32);
        rd(10'h1cc, 8'h00);
        rd(10'h1f0, 8'h00);
        rd(10'h000, 8'h00);
        chk("power", 3, aux_power_level_o);
    endtask
    // Reserved bits must drop; every power code lands on the pins
    task t_aux();
        acc(1, 10'h1c8, 8'hff);
        rd(10'h1c8, 8'h7a);
        chk("aux", 3'h7, {aux_source_select_o, aux_output_on_o, aux_power_level_o[0]});
        for (int p = 0; p < 4; p++)
        begin
            acc(1, 10'h1c8, {2'b00, p[1:0], 4'h0});
            chk("pwr", p, {aux_source_select_o, aux_output_on_o, aux_power_level_o});
        end
        // Lane 0 disabled: the write must leave the register alone
        avs_byteenable_i <= 4'he;
        acc(1, 10'h1c8, 8'h00);
        avs_byteenable_i <= 4'hf;
        rd(10'h1c8, 8'h30);
    endtask
    task t_adc_count();
        acc(1, 10'h1cc, 8'hff);
        rd(10'h1cc, 8'h07);
        repeat (2) @(posedge clock_i);
        chk("adc off", 1, adc_clock_off_o);
        adc_enable_i <= 1;
        repeat (2) @(posedge clock_i);
        chk("adc on", 0, adc_clock_off_o);
        for (int s = 0; s < 4; s++)
        begin
            lock_count_select_i <= s[1:0];
            repeat (2) @(posedge clock_i);
            chk("count", 11'h020 << s, lock_count_cycles_o);
        end
        chk("ndiv", 1, feedback_divider_powerdown_o);
        // Prescale off: back to the unscaled base count
        acc(1, 10'h1cc, 8'h00);
        chk("count base", 11'h028, lock_count_cycles_o);
        chk("ndiv off", 0, feedback_divider_powerdown_o);
    endtask
    // Reset in mid-run brings the aux controls back to their defaults
    task t_midreset();
        @(posedge clock_i);
        rst_n_i <= 0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1;
        rd(10'h1c8, 8'h32);
        rd(10'h1cc, 8'h00);
        chk("power rst", 3, aux_power_level_o);
        chk("on rst", 0, aux_output_on_o);
    endtask
    // Lock edge raises an event, read clears it, mask gates it
    task t_lock_irq();
        acc(1, 10'h1f8, 8'h03);
        lock_detect_i <= 1;
        repeat (4) @(posedge clock_i);
        chk("irq", 1, irq_o);
        rd(10'h1f0, 8'h01);
        rd(10'h1f4, 8'h01);
        repeat (2) @(posedge clock_i);
        chk("irq clr", 0, irq_o);
        acc(1, 10'h1f8, 8'h00);
        lock_detect_i <= 0;
        repeat (4) @(posedge clock_i);
        chk("irq mask", 0, irq_o);
        rd(10'h1f4, 8'h02);
    endtask
    // ============================================================
    // Clock, reset, sequence and watchdog
    initial forever #12.5 clock_i = !clock_i;
    initial
    begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1;
        t_reset();
        t_aux();
        t_adc_count();
        t_lock_irq();
        t_midreset();
        summarize();
    end
    // Whole run needs about a hundred cycles; this leaves wide margin
    initial
    begin
        repeat (5000) @(posedge clock_i);
        mismatches++;
        summarize();
    end
endmodule
